// >>> shared/pos_pkg.sv
// Constants and types shared by the port operation and link state registers
package pos_pkg;

	// ------------------------------------------------------------
	// Bus widths
	// ------------------------------------------------------------
	localparam int unsigned APB_ADDR_W = 12;
	localparam int unsigned APB_DATA_W = 32;
	localparam int unsigned APB_STRB_W = 4;
	localparam int unsigned REG_W = 8;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [11:0] EXT_CTRL_A_ADDR = 12'h000;
	localparam logic [11:0] EXT_CTRL_B_ADDR = 12'h004;
	localparam logic [11:0] OP_CTRL_ADDR = 12'h020;
	localparam logic [11:0] LINK_STATE_ADDR = 12'h030;
	localparam logic [11:0] PHY_SPACE_LO = 12'h100;
	localparam logic [11:0] PHY_SPACE_HI = 12'h1FF;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned OPC_TAIL_TAG_BIT = 2;
	localparam int unsigned OPC_SPLIT_LSB = 0;
	localparam int unsigned ST_SPEED_LSB = 3;
	localparam int unsigned ST_DUPLEX_BIT = 2;
	localparam int unsigned ST_TXFC_BIT = 1;
	localparam int unsigned ST_RXFC_BIT = 0;
	localparam int unsigned EXT_A_RXFC_BIT = 3;
	localparam int unsigned EXT_A_SPEED_BIT = 4;
	localparam int unsigned EXT_A_TXFC_BIT = 5;
	localparam int unsigned EXT_A_DUPLEX_BIT = 6;
	localparam int unsigned EXT_B_SPEED_BIT = 6;

	// ------------------------------------------------------------
	// Reset values and codes
	// ------------------------------------------------------------
	localparam logic [7:0] EXT_CTRL_A_RST = 8'h40;
	localparam logic [7:0] EXT_CTRL_B_RST = 8'h00;
	localparam logic TAIL_TAG_RST = 1'b0;
	localparam logic [1:0] SPLIT_RST = 2'h0;
	localparam logic [1:0] SPLIT_ONE = 2'h0;
	localparam logic [1:0] SPLIT_TWO = 2'h1;
	localparam logic [1:0] SPLIT_FOUR = 2'h2;
	localparam logic [1:0] SPLIT_RSVD = 2'h3;
	localparam int unsigned SYNC_STAGES_DEF = 2;
	localparam int unsigned PHY_IN_W = 8;

	typedef enum logic [1:0] {
		POS_Q_SINGLE,
		POS_Q_TWO,
		POS_Q_FOUR
	} pos_qmode_t;

endpackage

// >>> core/pos_sync.sv
// Multi-stage synchroniser for level inputs from outside the clock domain
`timescale 1ns/1ps
module pos_sync #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned STAGES = 2
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	import pos_pkg::*;

	logic [WIDTH-1:0] stage [STAGES];

	initial begin
		if (STAGES < 2 || WIDTH < 1) begin
			$error("pos_sync needs two stages and a width of one");
		end
	end

	// ------------------------------------------------------------
	// Flop chain
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < STAGES; i++) begin
				stage[i] <= '0;
			end
		end else begin
			stage[0] <= async_i;
			for (int i = 1; i < STAGES; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	assign sync_o = stage[STAGES-1];
endmodule

// >>> core/pos_status_mux.sv
// Builds the link state byte from PHY results or external port settings
`timescale 1ns/1ps
module pos_status_mux (
	input wire logic is_phy_i,
	input wire logic [7:0] ext_ctrl_a_i,
	input wire logic [7:0] ext_ctrl_b_i,
	input wire logic [1:0] phy_speed_i,
	input wire logic phy_duplex_i,
	input wire logic phy_link_up_i,
	input wire logic [1:0] phy_adv_pause_i,
	input wire logic phy_an_transmit_pause_enable_i,
	input wire logic phy_an_receive_pause_enable_i,
	output logic [7:0] status_o
);
	import pos_pkg::*;

	logic fc_allowed;

	// ------------------------------------------------------------
	// Status composition
	// ------------------------------------------------------------
	assign fc_allowed = (|phy_adv_pause_i) & phy_link_up_i;

	always_comb begin
		status_o = '0;
		if (is_phy_i) begin
			status_o[ST_SPEED_LSB +: 2] = phy_speed_i;
			status_o[ST_DUPLEX_BIT] = phy_duplex_i;
			status_o[ST_TXFC_BIT] = fc_allowed & phy_an_transmit_pause_enable_i;
			status_o[ST_RXFC_BIT] = fc_allowed & phy_an_receive_pause_enable_i;
		end else begin
			status_o[ST_SPEED_LSB +: 2] = {ext_ctrl_b_i[EXT_B_SPEED_BIT],
				ext_ctrl_a_i[EXT_A_SPEED_BIT]};
			status_o[ST_DUPLEX_BIT] = ext_ctrl_a_i[EXT_A_DUPLEX_BIT];
			status_o[ST_TXFC_BIT] = ext_ctrl_a_i[EXT_A_TXFC_BIT];
			status_o[ST_RXFC_BIT] = ext_ctrl_a_i[EXT_A_RXFC_BIT];
		end
	end
endmodule

// >>> core/pos_regs_top.sv
// Port operation control and link state registers behind an APB slave
//
// Behaviour
// - Tail-tag bit enables trailer tagging on port
// - Queue split bits 1:0, reset 00, 11 kept in field but leaves queue arrangement unchanged
// - Split 10 four, 01 two, 00 one queue
// - PHY port speed field shows link speed
// - External port speed mirrors control A/B bits
// - External port duplex mirrors control A bit 6
// - PHY port duplex shows established link duplex
// - External transmit pause mirrors control A bit 5
// - External receive pause mirrors control A bit 3
// - PHY pause needs advert, link and negotiation
// - PHY register window exists on PHY ports only
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module pos_regs_top #(
	parameter bit IS_PHY_PORT = 1'b0,
	parameter int unsigned SYNC_STAGES = pos_pkg::SYNC_STAGES_DEF
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [pos_pkg::APB_ADDR_W-1:0] paddr_i,
	input wire logic [pos_pkg::APB_DATA_W-1:0] pwdata_i,
	input wire logic [pos_pkg::APB_STRB_W-1:0] pstrb_i,
	output logic [pos_pkg::APB_DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [1:0] phy_speed_i,
	input wire logic phy_duplex_i,
	input wire logic phy_link_up_i,
	input wire logic [1:0] phy_adv_pause_i,
	input wire logic phy_an_transmit_pause_enable_i,
	input wire logic phy_an_receive_pause_enable_i,
	output logic tail_tag_en_o,
	output pos_pkg::pos_qmode_t queue_mode_o,
	output logic queue_prio_en_o,
	output logic [pos_pkg::REG_W-1:0] ext_ctrl_a_o,
	output logic [pos_pkg::REG_W-1:0] ext_ctrl_b_o,
	output logic [pos_pkg::REG_W-1:0] port_status_o
);
	import pos_pkg::*;

	initial begin
		if (SYNC_STAGES < 2) begin
			$error("pos_regs_top needs at least two synchroniser stages");
		end
	end

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [1:0] rst_pipe;
	logic rst_n;
	logic [PHY_IN_W-1:0] phy_raw;
	logic [PHY_IN_W-1:0] phy_sync;
	logic [1:0] phy_speed_s;
	logic phy_duplex_s;
	logic phy_link_up_s;
	logic [1:0] phy_adv_pause_s;
	logic phy_an_transmit_pause_enable_s;
	logic phy_an_receive_pause_enable_s;
	logic [7:0] ext_ctrl_a;
	logic [7:0] ext_ctrl_b;
	logic tail_tag_en;
	logic [1:0] split_field;
	pos_qmode_t queue_mode;
	logic queue_prio_en;
	logic [7:0] link_state;
	logic [7:0] next_link_state;
	logic [APB_DATA_W-1:0] prdata;
	logic [APB_DATA_W-1:0] next_prdata;
	logic hit_ext_a;
	logic hit_ext_b;
	logic hit_op;
	logic hit_state;
	logic hit_phy;
	logic mapped;
	logic setup_rd;
	logic access;
	logic wr_lane0;
	logic [7:0] op_readback;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end

	assign rst_n = rst_pipe[1];

	// ------------------------------------------------------------
	// PHY result synchronisation
	// ------------------------------------------------------------
	assign phy_raw = {phy_speed_i, phy_duplex_i, phy_link_up_i, phy_adv_pause_i,
		phy_an_transmit_pause_enable_i, phy_an_receive_pause_enable_i};

	pos_sync #(
		.WIDTH(PHY_IN_W),
		.STAGES(SYNC_STAGES)
	) u_phy_sync (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n),
		.async_i(phy_raw),
		.sync_o(phy_sync)
	);

	assign phy_speed_s = phy_sync[7:6];
	assign phy_duplex_s = phy_sync[5];
	assign phy_link_up_s = phy_sync[4];
	assign phy_adv_pause_s = phy_sync[3:2];
	assign phy_an_transmit_pause_enable_s = phy_sync[1];
	assign phy_an_receive_pause_enable_s = phy_sync[0];

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign hit_ext_a = (paddr_i == EXT_CTRL_A_ADDR);
	assign hit_ext_b = (paddr_i == EXT_CTRL_B_ADDR);
	assign hit_op = (paddr_i == OP_CTRL_ADDR);
	assign hit_state = (paddr_i == LINK_STATE_ADDR);
	assign hit_phy = IS_PHY_PORT && (paddr_i >= PHY_SPACE_LO) && (paddr_i <= PHY_SPACE_HI);
	assign mapped = hit_ext_a | hit_ext_b | hit_op | hit_state | hit_phy;
	assign access = psel_i & penable_i;
	assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
	assign wr_lane0 = access & pwrite_i & pstrb_i[0];

	// ------------------------------------------------------------
	// APB handshake
	// ------------------------------------------------------------
	assign pready_o = 1'b1;
	assign pslverr_o = access & ~mapped;

	// ------------------------------------------------------------
	// External port control registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ext_ctrl_a <= EXT_CTRL_A_RST;
		end else if (wr_lane0 && hit_ext_a) begin
			ext_ctrl_a <= pwdata_i[7:0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ext_ctrl_b <= EXT_CTRL_B_RST;
		end else if (wr_lane0 && hit_ext_b) begin
			ext_ctrl_b <= pwdata_i[7:0];
		end
	end

	// ------------------------------------------------------------
	// Tail tag enable
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tail_tag_en <= TAIL_TAG_RST;
		end else if (wr_lane0 && hit_op) begin
			tail_tag_en <= pwdata_i[OPC_TAIL_TAG_BIT];
		end
	end

	// ------------------------------------------------------------
	// Egress queue split field and arrangement
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			split_field <= SPLIT_RST;
		end else if (wr_lane0 && hit_op) begin
			split_field <= pwdata_i[OPC_SPLIT_LSB +: 2];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			queue_mode <= POS_Q_SINGLE;
			queue_prio_en <= 1'b0;
		end else if (wr_lane0 && hit_op) begin
			unique case (pwdata_i[OPC_SPLIT_LSB +: 2])
				SPLIT_ONE: begin
					queue_mode <= POS_Q_SINGLE;
					queue_prio_en <= 1'b0;
				end
				SPLIT_TWO: begin
					queue_mode <= POS_Q_TWO;
					queue_prio_en <= 1'b1;
				end
				SPLIT_FOUR: begin
					queue_mode <= POS_Q_FOUR;
					queue_prio_en <= 1'b1;
				end
				SPLIT_RSVD: begin
					queue_mode <= queue_mode;
					queue_prio_en <= queue_prio_en;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Link state register
	// ------------------------------------------------------------
	pos_status_mux u_status_mux (
		.is_phy_i(IS_PHY_PORT),
		.ext_ctrl_a_i(ext_ctrl_a),
		.ext_ctrl_b_i(ext_ctrl_b),
		.phy_speed_i(phy_speed_s),
		.phy_duplex_i(phy_duplex_s),
		.phy_link_up_i(phy_link_up_s),
		.phy_adv_pause_i(phy_adv_pause_s),
		.phy_an_transmit_pause_enable_i(phy_an_transmit_pause_enable_s),
		.phy_an_receive_pause_enable_i(phy_an_receive_pause_enable_s),
		.status_o(next_link_state)
	);

	// Bus writes never reach this register
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			link_state <= 8'h00;
		end else begin
			link_state <= {3'h0, next_link_state[4:0]};
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	assign op_readback = {5'h00, tail_tag_en, split_field};

	always_comb begin
		next_prdata = '0;
		if (hit_ext_a) begin
			next_prdata[7:0] = ext_ctrl_a;
		end else if (hit_ext_b) begin
			next_prdata[7:0] = ext_ctrl_b;
		end else if (hit_op) begin
			next_prdata[7:0] = op_readback;
		end else if (hit_state) begin
			next_prdata[7:0] = link_state;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= '0;
		end else if (setup_rd) begin
			prdata <= next_prdata;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata_o = prdata;
	assign tail_tag_en_o = tail_tag_en;
	assign queue_mode_o = queue_mode;
	assign queue_prio_en_o = queue_prio_en;
	assign ext_ctrl_a_o = ext_ctrl_a;
	assign ext_ctrl_b_o = ext_ctrl_b;
	assign port_status_o = link_state;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_TAIL_TAG_FOLLOWS: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(wr_lane0 && hit_op) |=> (tail_tag_en_o == $past(pwdata_i[OPC_TAIL_TAG_BIT])))
		else $error("tail tag enable did not follow write");

	AST_TAIL_TAG_HOLDS: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		!(wr_lane0 && hit_op) |=> $stable(tail_tag_en_o))
		else $error("tail tag enable changed without write");

	AST_SPLIT_RSVD_KEEPS: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(wr_lane0 && hit_op && pwdata_i[1:0] == SPLIT_RSVD) |=>
		($stable(queue_mode_o) && $stable(queue_prio_en_o) && split_field == SPLIT_RSVD))
		else $error("reserved split changed the queue arrangement");

	AST_SPLIT_FOUR: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(wr_lane0 && hit_op && pwdata_i[1:0] == SPLIT_FOUR) |=>
		(queue_mode_o == POS_Q_FOUR && queue_prio_en_o))
		else $error("split four not applied");

	AST_SPLIT_TWO_ONE: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(wr_lane0 && hit_op && pwdata_i[1:0] != SPLIT_RSVD && pwdata_i[1:0] != SPLIT_FOUR) |=>
		(queue_prio_en_o == $past(pwdata_i[0])) &&
		(queue_mode_o == ($past(pwdata_i[0]) ? POS_Q_TWO : POS_Q_SINGLE)))
		else $error("split two or single not applied");

	AST_PHY_SPEED_DUPLEX: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		IS_PHY_PORT |=> (port_status_o[4:3] == $past(phy_speed_s)) &&
		(port_status_o[ST_DUPLEX_BIT] == $past(phy_duplex_s)))
		else $error("PHY speed or duplex not reported");

	AST_EXT_SPEED: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		!IS_PHY_PORT |=> port_status_o[4:3] ==
		{$past(ext_ctrl_b[EXT_B_SPEED_BIT]), $past(ext_ctrl_a[EXT_A_SPEED_BIT])})
		else $error("external speed not mirrored");

	AST_EXT_DUPLEX_FC: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(!IS_PHY_PORT && wr_lane0 && hit_ext_a) |=> ##1
		(port_status_o[ST_DUPLEX_BIT] == $past(pwdata_i[EXT_A_DUPLEX_BIT], 2)) &&
		(port_status_o[ST_TXFC_BIT] == $past(pwdata_i[EXT_A_TXFC_BIT], 2)) &&
		(port_status_o[ST_RXFC_BIT] == $past(pwdata_i[EXT_A_RXFC_BIT], 2)))
		else $error("external duplex or pause not mirrored two cycles after write");

	AST_PHY_PAUSE_GATED: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(IS_PHY_PORT && (port_status_o[ST_TXFC_BIT] || port_status_o[ST_RXFC_BIT])) |->
		($past(phy_link_up_s) && $past(|phy_adv_pause_s)))
		else $error("PHY pause reported without advert and link");

	AST_PHY_SPACE: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(access && paddr_i >= PHY_SPACE_LO && paddr_i <= PHY_SPACE_HI) |->
		(pslverr_o == !IS_PHY_PORT))
		else $error("PHY window answer wrong for port type");

	AST_STATE_RESERVED: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(access && !pwrite_i && hit_state) |-> (prdata_o[APB_DATA_W-1:5] == '0))
		else $error("link state reserved bits not zero");

	AST_STRB_GATES: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(access && pwrite_i && !pstrb_i[0] && hit_op) |=>
		($stable(split_field) && $stable(tail_tag_en_o)))
		else $error("operation control changed without lane 0 strobe");

	AST_EXT_A_TAKES: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(wr_lane0 && hit_ext_a) |=> (ext_ctrl_a_o == $past(pwdata_i[7:0])))
		else $error("external control A write not taken");

	AST_EXT_B_TAKES: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(wr_lane0 && hit_ext_b) |=> (ext_ctrl_b_o == $past(pwdata_i[7:0])))
		else $error("external control B write not taken");

	AST_UNMAPPED_NO_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		(access && pwrite_i && !mapped) |=>
		($stable(ext_ctrl_a_o) && $stable(ext_ctrl_b_o) && $stable(tail_tag_en_o) &&
		$stable(split_field)))
		else $error("write to unmapped address changed a register");

endmodule

// >>> tb/port_op_ctrl_status_regs_tb_top.sv
// Self-checking bench for the port operation and link state registers
`timescale 1ns/1ps
module port_op_ctrl_status_regs_tb_top;
	import pos_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [1:0] ph_spd = 2'h0;
	logic [1:0] ph_adv = 2'h0;
	logic ph_dup = 1'b0;
	logic ph_up = 1'b0;
	logic ph_tx = 1'b0;
	logic ph_rx = 1'b0;
	logic [31:0] prd_n, prd_p, rd_n, rd_p;
	logic rdy_n, rdy_p, er_n, er_p, se_n, se_p, tail_n, prio_n;
	pos_qmode_t q_n, exp_q;
	logic [7:0] exta_n, extb_n, st_n, st_p, a, b;
	logic [1:0] sp;
	logic tt;
	int err_total = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [11:0] wins [4] = '{PHY_SPACE_LO, PHY_SPACE_HI, 12'h008, 12'hFFC};

	always #2.5 sys_clk_i = ~sys_clk_i;

	pos_regs_top #(.IS_PHY_PORT(1'b0)) pos_regs_top_inst (.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prd_n),
		.pready_o(rdy_n), .pslverr_o(se_n), .phy_speed_i(ph_spd), .phy_duplex_i(ph_dup),
		.phy_link_up_i(ph_up), .phy_adv_pause_i(ph_adv), .phy_an_transmit_pause_enable_i(ph_tx),
		.phy_an_receive_pause_enable_i(ph_rx), .tail_tag_en_o(tail_n), .queue_mode_o(q_n),
		.queue_prio_en_o(prio_n), .ext_ctrl_a_o(exta_n), .ext_ctrl_b_o(extb_n),
		.port_status_o(st_n));
	// Operation control writes reach one port only, so one tagged port at most
	pos_regs_top #(.IS_PHY_PORT(1'b1)) pos_regs_top_phy_inst (.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i), .psel_i(psel & (paddr != OP_CTRL_ADDR)), .penable_i(penable),
		.pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prd_p),
		.pready_o(rdy_p), .pslverr_o(se_p), .phy_speed_i(ph_spd), .phy_duplex_i(ph_dup),
		.phy_link_up_i(ph_up), .phy_adv_pause_i(ph_adv), .phy_an_transmit_pause_enable_i(ph_tx),
		.phy_an_receive_pause_enable_i(ph_rx), .tail_tag_en_o(), .queue_mode_o(), .queue_prio_en_o(),
		.ext_ctrl_a_o(), .ext_ctrl_b_o(), .port_status_o(st_p));

	// ------------------------------------------------------------
	// Reporting and bus tasks
	// ------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		cmp_count++;
		if (e !== g) begin
			err_total++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge sys_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk_i);
		end while (!(rdy_n === 1'b1 && rdy_p === 1'b1));
		rd_n = prd_n;
		rd_p = prd_p;
		er_n = se_n;
		er_p = se_p;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic pos_qmode_t qmode_of(input logic [1:0] v, input pos_qmode_t pv);
		case (v)
			2'h0: return POS_Q_SINGLE;
			2'h1: return POS_Q_TWO;
			2'h2: return POS_Q_FOUR;
			default: return pv;
		endcase
	endfunction

	function automatic logic [7:0] ext_stat(input logic [7:0] ca, input logic [7:0] cb);
		return {3'h0, cb[6], ca[4], ca[6], ca[5], ca[3]};
	endfunction

	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'hA7B4));
		repeat (6) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		apb(1'b0, OP_CTRL_ADDR, 32'h0, 4'hF);
		chk32("opctl reset", 32'h0, rd_n);
		apb(1'b0, LINK_STATE_ADDR, 32'h0, 4'hF);
		chk32("state reset", {24'h0, ext_stat(EXT_CTRL_A_RST, EXT_CTRL_B_RST)}, rd_n);
		chk1("tail reset", 1'b0, tail_n);
		chk32("qmode reset", {30'h0, POS_Q_SINGLE}, {30'h0, q_n});
		// Queue split codes and tail tag
		exp_q = POS_Q_SINGLE;
		for (int i = 0; i < 10; i++) begin
			sp = (i < 4) ? 2'(i + 2) : 2'($urandom);
			tt = 1'($urandom);
			apb(1'b1, OP_CTRL_ADDR, {24'($urandom), 5'($urandom), tt, sp}, 4'hF);
			exp_q = qmode_of(sp, exp_q);
			@(posedge sys_clk_i);
			chk1("tail", tt, tail_n);
			chk32("qmode", {30'h0, exp_q}, {30'h0, q_n});
			chk1("prio", exp_q != POS_Q_SINGLE, prio_n);
			apb(1'b1, OP_CTRL_ADDR, {29'h0, ~tt, ~sp}, 4'hE);
			apb(1'b0, OP_CTRL_ADDR, 32'h0, 4'hF);
			chk32("opctl", {29'h0, tt, sp}, rd_n);
		end
		// External port mirroring
		for (int i = 0; i < 14; i++) begin
			a = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			b = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			apb(1'b1, EXT_CTRL_A_ADDR, {24'($urandom), a}, 4'h1);
			apb(1'b1, EXT_CTRL_B_ADDR, {24'($urandom), b}, 4'h1);
			@(posedge sys_clk_i);
			@(posedge sys_clk_i);
			chk32("ext a", {24'h0, a}, {24'h0, exta_n});
			chk32("ext b", {24'h0, b}, {24'h0, extb_n});
			chk32("state out", {24'h0, ext_stat(a, b)}, {24'h0, st_n});
			apb(1'b1, LINK_STATE_ADDR, $urandom, 4'hF);
			chk1("state wr err", 1'b0, er_n);
			apb(1'b0, LINK_STATE_ADDR, 32'h0, 4'hF);
			chk32("state rd", {24'h0, ext_stat(a, b)}, rd_n);
		end
		// Integrated PHY link results
		for (int i = 0; i < 16; i++) begin
			@(posedge sys_clk_i);
			ph_spd <= (i < 3) ? 2'(i) : 2'($urandom);
			ph_dup <= 1'($urandom);
			ph_up <= (i < 3) ? 1'b1 : 1'($urandom);
			ph_adv <= (i < 3) ? 2'h3 : 2'($urandom);
			ph_tx <= 1'($urandom);
			ph_rx <= 1'($urandom);
			repeat (6) @(posedge sys_clk_i);
			apb(1'b0, LINK_STATE_ADDR, 32'h0, 4'hF);
			a = {3'h0, ph_spd, ph_dup, ph_up & (|ph_adv) & ph_tx, ph_up & (|ph_adv) & ph_rx};
			chk32("phy state", {24'h0, a}, rd_p);
			chk32("phy state out", {24'h0, a}, {24'h0, st_p});
		end
		// PHY window and unmapped places
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, wins[i], $urandom, 4'hF);
			chk1("wr err n", 1'b1, er_n);
			chk1("wr err p", i >= 2, er_p);
			apb(1'b0, wins[i], 32'h0, 4'hF);
			chk1("rd err n", 1'b1, er_n);
			chk1("rd err p", i >= 2, er_p);
			chk32("rd data p", 32'h0, rd_p);
		end
		close_out();
	end
endmodule
